// [include/fpa_params.svh]
`ifndef FPA_PARAMS_SVH
`define FPA_PARAMS_SVH

// ****************************************************************
// Function codes
// ****************************************************************
`define FPA_FN_PROG_PAGE   8'h00
`define FPA_FN_READ_VER    8'h01
`define FPA_FN_MISC_WRITE  8'h02
`define FPA_FN_MISC_READ   8'h03
`define FPA_FN_ERASE       8'h04
`define FPA_FN_SECTOR_CRC  8'h05
`define FPA_FN_GLOBAL_CRC  8'h06

// ****************************************************************
// Misc write targets
// ****************************************************************
`define FPA_SEL_CFG        8'h00
`define FPA_SEL_BOOT_VECTOR_BYTE    8'h02
`define FPA_SEL_BOOT_STATUS_BYTE   8'h03
`define FPA_SEL_CLR_PROT   8'h0A
`define FPA_SEL_SEC_LO     8'h08
`define FPA_SEL_SEC_HI     8'h0F

// ****************************************************************
// Bit positions and values
// ****************************************************************
`define FPA_CWP_BIT        6
`define FPA_DISABLE_CLEAR_PROTECT_BIT_BIT       7
`define FPA_ST_OI          0
`define FPA_ST_SV          1
`define FPA_ST_HVE         2
`define FPA_ST_VE          3
`define FPA_KEY_VALUE      8'h96
`define FPA_VERSION_ID     8'h5A
`define FPA_BOOT_STATUS_BYTE_RST   8'h00
`define FPA_ZERO8          8'h00

`endif

// [include/fpa_pkg.sv]
package fpa_pkg;
   typedef enum logic [1:0] {
      FPA_MODE_ISP,
      FPA_MODE_IAP,
      FPA_MODE_ICP,
      FPA_MODE_PAR
   } fpa_mode_t;

   typedef enum {
      FPA_IDLE,
      FPA_CYCLE,
      FPA_DONE
   } fpa_state_t;
endpackage : fpa_pkg

// [verilog/fpa_sync.sv]
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Reset release synchroniser
// ****************************************************************
module fpa_sync (
   input  wire logic ref_clk_i,
   input  wire logic rstn_i,
   output logic      rstn_o
);
   logic meta_r;
   logic hold_r;

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_r <= 1'b0;
         hold_r <= 1'b0;
      end else begin
         meta_r <= 1'b1;
         hold_r <= meta_r;
      end
   end

   assign rstn_o = hold_r;
endmodule : fpa_sync

`default_nettype wire

// [verilog/fpa_iap_core.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fpa_params.svh"


module fpa_iap_core (
   input  wire logic             ref_clk_i,
   input  wire logic             rstn_i,
   input  wire fpa_pkg::fpa_mode_t mode_i,
   input  wire logic             call_i,
   input  wire logic [7:0]       acc_i,
   input  wire logic [7:0]       working_register_five_i,
   input  wire logic [7:0]       working_register_seven_i,
   input  wire logic             user_flag_one_i,
   input  wire logic [7:0]       key_i,
   input  wire logic             irq_i,
   input  wire logic             flash_done_i,
   input  wire logic             flash_sec_fail_i,
   input  wire logic             flash_hv_fail_i,
   input  wire logic             flash_verify_fail_i,
   output logic                  key_clear_o,
   output logic                  mcu_reset_o,
   output logic                  program_idle_o,
   output logic                  flash_start_o,
   output logic                  flash_abort_o,
   output logic                  done_o,
   output logic                  carry_o,
   output logic [7:0]            working_register_seven_o,
   output logic [7:0]            boot_status_byte_o,
   output logic                  config_write_protect_bit_o,
   output logic                  disable_clear_protect_bit_o
);
   import fpa_pkg::*;

   logic       rstn;
   fpa_state_t state_r;
   fpa_state_t state_nxt;
   logic [7:0] boot_status_byte_r;
   logic [7:0] pend_boot_status_byte_r;
   logic       pend_boot_status_byte_wr_r;
   logic       carry_r;
   logic [7:0] ret_r;
   logic       reset_r;
   logic       key_clear_r;

   fpa_sync u_sync (
      .ref_clk_i (ref_clk_i),
      .rstn_i    (rstn_i),
      .rstn_o    (rstn)
   );

   // ****************************************************************
   // Call decode
   // ****************************************************************
   function automatic logic is_cfg_sel(input logic [7:0] sel);
      is_cfg_sel = (sel == `FPA_SEL_CFG) || (sel == `FPA_SEL_BOOT_VECTOR_BYTE) ||
                   (sel == `FPA_SEL_BOOT_STATUS_BYTE);
   endfunction : is_cfg_sel

   wire soft_mode  = (mode_i == FPA_MODE_ISP) || (mode_i == FPA_MODE_IAP);
   wire fn_prog    = (acc_i == `FPA_FN_PROG_PAGE) && !user_flag_one_i;
   wire fn_ver     = (acc_i == `FPA_FN_READ_VER);
   wire fn_misc    = (acc_i == `FPA_FN_MISC_WRITE);
   wire fn_cycle   = (acc_i == `FPA_FN_ERASE) || (acc_i == `FPA_FN_SECTOR_CRC) ||
                     (acc_i == `FPA_FN_GLOBAL_CRC);
   wire needs_key  = fn_prog || fn_misc || (acc_i == `FPA_FN_ERASE);
   wire key_ok     = (key_i == `FPA_KEY_VALUE);
   wire sel_clr    = fn_misc && (working_register_seven_i == `FPA_SEL_CLR_PROT);
   wire sel_cfg    = fn_misc && is_cfg_sel(working_register_seven_i);
   wire sel_sec    = fn_misc && !sel_clr &&
                     (working_register_seven_i >= `FPA_SEL_SEC_LO) &&
                     (working_register_seven_i <= `FPA_SEL_SEC_HI);
   wire sel_bad    = fn_misc && !sel_clr && !sel_cfg && !sel_sec;
   wire config_write_protect_bit        = boot_status_byte_r[`FPA_CWP_BIT];
   wire disable_clear_protect_bit       = boot_status_byte_r[`FPA_DISABLE_CLEAR_PROTECT_BIT_BIT];
   wire cfg_block  = sel_cfg && soft_mode && config_write_protect_bit;
   wire clr_block  = sel_clr && soft_mode && disable_clear_protect_bit;
   wire start_ok   = call_i && (state_r == FPA_IDLE) && (!needs_key || key_ok);
   wire refuse     = cfg_block || clr_block || sel_bad;
   wire go_cycle   = start_ok && !refuse && (fn_prog || fn_cycle || sel_cfg || sel_sec);
   wire cyc_err    = irq_i || flash_sec_fail_i || flash_hv_fail_i ||
                     (flash_done_i && flash_verify_fail_i);
   wire [7:0] err_code = {4'h0, flash_verify_fail_i && flash_done_i, flash_hv_fail_i,
                          flash_sec_fail_i, irq_i};

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         FPA_IDLE: begin
            if (go_cycle) begin
               state_nxt = FPA_CYCLE;
            end else if (start_ok) begin
               state_nxt = FPA_DONE;
            end
         end
         FPA_CYCLE: begin
            if (cyc_err || flash_done_i) begin
               state_nxt = FPA_DONE;
            end
         end
         default: begin
            state_nxt = FPA_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rstn) begin
      if (!rstn) begin
         state_r <= FPA_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ****************************************************************
   // Return values and carry
   // ****************************************************************
   always_ff @(posedge ref_clk_i or negedge rstn) begin
      if (!rstn) begin
         carry_r <= 1'b0;
         ret_r   <= `FPA_ZERO8;
      end else if (state_r == FPA_IDLE && start_ok) begin
         if (refuse) begin
            carry_r <= 1'b1;
            ret_r   <= 8'h01 << `FPA_ST_SV;
         end else if (fn_ver) begin
            carry_r <= 1'b0;
            ret_r   <= `FPA_VERSION_ID;
         end else begin
            carry_r <= 1'b0;
            ret_r   <= `FPA_ZERO8;
         end
      end else if (state_r == FPA_CYCLE && cyc_err) begin
         carry_r <= 1'b1;
         ret_r   <= err_code;
      end
   end

   // ****************************************************************
   // Protection bits
   // ****************************************************************
   // A status-byte write is held pending so that a failed or aborted
   // cycle never leaves the protection bits in a half-written state.
   always_ff @(posedge ref_clk_i or negedge rstn) begin
      if (!rstn) begin
         pend_boot_status_byte_r    <= `FPA_ZERO8;
         pend_boot_status_byte_wr_r <= 1'b0;
         boot_status_byte_r         <= `FPA_BOOT_STATUS_BYTE_RST;
      end else begin
         if (go_cycle) begin
            pend_boot_status_byte_r    <= working_register_five_i;
            pend_boot_status_byte_wr_r <= fn_misc &&
                                  (working_register_seven_i == `FPA_SEL_BOOT_STATUS_BYTE);
         end
         if (state_r == FPA_CYCLE && flash_done_i && !cyc_err && pend_boot_status_byte_wr_r) begin
            boot_status_byte_r <= pend_boot_status_byte_r;
         end else if (state_r == FPA_IDLE && start_ok && sel_clr && !clr_block) begin
            boot_status_byte_r[`FPA_CWP_BIT] <= 1'b0;
            if (!soft_mode) begin
               boot_status_byte_r[`FPA_DISABLE_CLEAR_PROTECT_BIT_BIT] <= 1'b0;
            end
         end
      end
   end

   // ****************************************************************
   // Key handling
   // ****************************************************************
   always_ff @(posedge ref_clk_i or negedge rstn) begin
      if (!rstn) begin
         reset_r     <= 1'b0;
         key_clear_r <= 1'b0;
      end else begin
         reset_r     <= call_i && (state_r == FPA_IDLE) && needs_key && !key_ok;
         key_clear_r <= (state_nxt == FPA_DONE) && (state_r != FPA_DONE);
      end
   end

   assign key_clear_o                 = key_clear_r;
   assign mcu_reset_o                 = reset_r;
   assign program_idle_o              = (state_r == FPA_CYCLE);
   assign flash_start_o               = go_cycle;
   assign flash_abort_o               = (state_r == FPA_CYCLE) && irq_i;
   assign done_o                      = (state_r == FPA_DONE);
   assign carry_o                     = carry_r;
   assign working_register_seven_o    = ret_r;
   assign boot_status_byte_o          = boot_status_byte_r;
   assign config_write_protect_bit_o  = config_write_protect_bit;
   assign disable_clear_protect_bit_o = disable_clear_protect_bit;

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence s_irq_in_cycle;
      (state_r == FPA_CYCLE) && irq_i;
   endsequence

   chk_irq_aborts: assert property (@(posedge ref_clk_i) disable iff (!rstn)
      s_irq_in_cycle |-> flash_abort_o ##1 (done_o && carry_o && ret_r[`FPA_ST_OI]))
      else $error("interrupt did not abort the cycle");

   chk_status_high_zero: assert property (@(posedge ref_clk_i) disable iff (!rstn)
      done_o |-> (ret_r[7:4] == 4'h0) || !carry_o)
      else $error("status upper bits not zero");

   chk_cfg_blocked: assert property (@(posedge ref_clk_i) disable iff (!rstn)
      (start_ok && cfg_block) |=> (done_o && carry_o && $stable(boot_status_byte_r)))
      else $error("protected configuration write not refused");

   chk_icp_no_block: assert property (@(posedge ref_clk_i) disable iff (!rstn)
      (start_ok && sel_cfg && !soft_mode) |=> program_idle_o)
      else $error("protection applied outside software modes");

   chk_disable_clear_protect_bit_rejects: assert property (@(posedge ref_clk_i) disable iff (!rstn)
      (start_ok && sel_clr && soft_mode && disable_clear_protect_bit) |=> (carry_o && $stable(boot_status_byte_r)))
      else $error("clear command accepted while disabled");

   chk_clear_par: assert property (@(posedge ref_clk_i) disable iff (!rstn)
      (start_ok && sel_clr && !soft_mode) |=> (!config_write_protect_bit && !disable_clear_protect_bit))
      else $error("clear in programmer mode left protection bits");

   chk_no_key_reset: assert property (@(posedge ref_clk_i) disable iff (!rstn)
      (call_i && state_r == FPA_IDLE && needs_key && !key_ok) |=> (mcu_reset_o && !program_idle_o))
      else $error("missing key did not reset");

   chk_boot_status_byte_late: assert property (@(posedge ref_clk_i) disable iff (!rstn)
      (program_idle_o && (cyc_err || !flash_done_i)) |=> $stable(boot_status_byte_r))
      else $error("protection bits changed before cycle end");

   chk_version_ret: assert property (@(posedge ref_clk_i) disable iff (!rstn)
      (start_ok && fn_ver) |=> (ret_r == `FPA_VERSION_ID && !carry_o))
      else $error("version id not returned");

   chk_verify_flag: assert property (@(posedge ref_clk_i) disable iff (!rstn)
      (program_idle_o && flash_done_i && flash_verify_fail_i && !irq_i) |=> ret_r[`FPA_ST_VE])
      else $error("verify error not flagged");
endmodule : fpa_iap_core

`default_nettype wire

// [sim/fpa_flash_model.sv]
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Flash array stand-in with self-timed cycles and injectable faults
// ****************************************************************
module fpa_flash_model (
   input  wire logic       ref_clk_i,
   input  wire logic       rstn_i,
   input  wire logic       program_idle_i,
   input  wire logic [1:0] fault_sel_i,
   input  wire logic [7:0] cycle_len_i,
   output logic            flash_done_o,
   output logic            sec_fail_o,
   output logic            hv_fail_o,
   output logic            verify_fail_o
);
   logic [7:0] cnt_r;
   logic       done_r;
   wire        hard_fault = (fault_sel_i == 2'h1) || (fault_sel_i == 2'h2);

   // Leaving program-idle restarts the count, so an aborted cycle never completes late.
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_r  <= 8'h00;
         done_r <= 1'b0;
      end else begin
         cnt_r  <= program_idle_i ? cnt_r + 8'h01 : 8'h00;
         done_r <= program_idle_i && !hard_fault && (cnt_r == cycle_len_i);
      end
   end

   assign flash_done_o  = done_r;
   assign sec_fail_o    = program_idle_i && (cnt_r >= 8'h02) && (fault_sel_i == 2'h1);
   assign hv_fail_o     = program_idle_i && (cnt_r >= 8'h02) && (fault_sel_i == 2'h2);
   assign verify_fail_o = done_r && (fault_sel_i == 2'h3);
endmodule : fpa_flash_model

`default_nettype wire

// [sim/flash_config_protect_and_iap_calls_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fpa_params.svh"

module flash_config_protect_and_iap_calls_tb;
   import fpa_pkg::*;
   logic ref_clk = 1'b0, rstn = 1'b0, call = 1'b0, irq = 1'b0, uf1 = 1'b0;
   logic [7:0] acc = 8'h00, r5 = 8'h00, r7 = 8'h00, key_q = 8'h00, len = 8'h04;
   logic [1:0] fsel = 2'h0;
   fpa_mode_t  mode = FPA_MODE_IAP;
   wire        kclr, mrst, pidle, fstart, fabort, done, carry, config_write_protect_bit, disable_clear_protect_bit;
   wire        fdone, fsec, fhv, fver;
   wire [7:0]  ret, bsb;
   int         fail_count = 0, n_checks = 0, cyc = 0;
   logic       got, rst_seen, mid_cwp, idle_seen, abort_seen, start_seen;

   always #20 ref_clk = ~ref_clk;

   fpa_iap_core dut (.ref_clk_i(ref_clk), .rstn_i(rstn), .mode_i(mode), .call_i(call),
      .acc_i(acc), .working_register_five_i(r5), .working_register_seven_i(r7),
      .user_flag_one_i(uf1), .key_i(key_q), .irq_i(irq), .flash_done_i(fdone),
      .flash_sec_fail_i(fsec), .flash_hv_fail_i(fhv), .flash_verify_fail_i(fver),
      .key_clear_o(kclr), .mcu_reset_o(mrst), .program_idle_o(pidle),
      .flash_start_o(fstart), .flash_abort_o(fabort), .done_o(done), .carry_o(carry),
      .working_register_seven_o(ret), .boot_status_byte_o(bsb),
      .config_write_protect_bit_o(config_write_protect_bit), .disable_clear_protect_bit_o(disable_clear_protect_bit));

   fpa_flash_model flash (.ref_clk_i(ref_clk), .rstn_i(rstn), .program_idle_i(pidle),
      .fault_sel_i(fsel), .cycle_len_i(len), .flash_done_o(fdone), .sec_fail_o(fsec),
      .hv_fail_o(fhv), .verify_fail_o(fver));

   // The key in RAM is wiped when the core says so, as the caller would see it.
   always @(posedge ref_clk) if (kclr === 1'b1) key_q <= 8'h00;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         end_of_test();
      end
   end

   // Waits for the answer; irq is raised irq_at+1 cycles after the call was taken.
   task automatic do_call(input logic [7:0] fn, sel, dat, key, input int irq_at);
      @(posedge ref_clk);
      acc <= fn; r7 <= sel; r5 <= dat; key_q <= key; call <= 1'b1;
      @(negedge ref_clk);
      start_seen = fstart;
      @(posedge ref_clk);
      call <= 1'b0;
      #1;
      {got, rst_seen, mid_cwp, idle_seen, abort_seen} = 5'b0;
      for (int n = 0; n < 300; n++) begin
         idle_seen |= pidle;
         abort_seen |= fabort;
         mid_cwp |= pidle & config_write_protect_bit;
         if (done === 1'b1 || mrst === 1'b1) break;
         @(posedge ref_clk);
         if (n == irq_at) irq <= 1'b1;
         #1;
      end
      got = done;
      rst_seen = mrst;
      @(posedge ref_clk);
      irq <= 1'b0;
   endtask : do_call

   task automatic t_version;
      do_call(`FPA_FN_READ_VER, 8'h00, 8'h00, 8'h00, -1);
      check({got, carry}, 2'b10);
      check(ret, `FPA_VERSION_ID);
      check(start_seen, 8'h00);
   endtask : t_version

   task automatic t_program;
      for (int i = 0; i < 2; i++) begin
         len <= i ? 8'h28 : 8'h01;
         do_call(`FPA_FN_PROG_PAGE, 8'h40, 8'h00, `FPA_KEY_VALUE, -1);
         check({got, start_seen, idle_seen, carry}, 4'b1110);
         check(ret, 8'h00);
         // The key is wiped on the edge after the answer, so look mid-cycle.
         @(negedge ref_clk);
         check(key_q, 8'h00);
      end
      @(posedge ref_clk);
      uf1 <= 1'b1;
      do_call(`FPA_FN_PROG_PAGE, 8'h40, 8'h00, `FPA_KEY_VALUE, -1);
      check({got, start_seen, idle_seen, carry}, 4'b1000);
      uf1 <= 1'b0;
   endtask : t_program

   task automatic t_irq;
      len <= 8'h0A;
      do_call(`FPA_FN_ERASE, 8'h00, 8'h00, `FPA_KEY_VALUE, 2);
      check({got, abort_seen, carry}, 3'b111);
      check(ret, 8'h01);
      do_call(`FPA_FN_GLOBAL_CRC, 8'h00, 8'h00, 8'h00, 3);
      check({got, abort_seen, carry}, 3'b111);
      check(ret, 8'h01);
      do_call(`FPA_FN_ERASE, 8'h00, 8'h00, `FPA_KEY_VALUE, -1);
      check({got, idle_seen, carry}, 3'b110);
      do_call(`FPA_FN_SECTOR_CRC, 8'h00, 8'h00, 8'h00, -1);
      check({got, idle_seen, carry}, 3'b110);
   endtask : t_irq

   task automatic t_faults;
      len <= 8'h06;
      for (int f = 1; f < 4; f++) begin
         fsel <= f[1:0];
         do_call(`FPA_FN_PROG_PAGE, 8'h40, 8'h00, `FPA_KEY_VALUE, -1);
         check({got, carry}, 2'b11);
         check(ret, 8'h01 << f);
      end
      fsel <= 2'h0;
   endtask : t_faults

   task automatic t_protect;
      do_call(`FPA_FN_MISC_WRITE, `FPA_SEL_BOOT_STATUS_BYTE, 8'hC0, `FPA_KEY_VALUE, -1);
      check({carry, mid_cwp, config_write_protect_bit, disable_clear_protect_bit}, 4'b0011);
      check(bsb, 8'hC0);
      for (int m = 0; m < 2; m++) begin
         mode <= m ? FPA_MODE_IAP : FPA_MODE_ISP;
         do_call(`FPA_FN_MISC_WRITE, m ? `FPA_SEL_BOOT_VECTOR_BYTE : `FPA_SEL_CFG, 8'h55, 8'h96, -1);
         check({got, carry}, 2'b11);
         check(ret, 8'h02);
      end
      do_call(`FPA_FN_MISC_WRITE, `FPA_SEL_CLR_PROT, 8'h00, `FPA_KEY_VALUE, -1);
      check({carry, config_write_protect_bit}, 2'b11);
      check(ret, 8'h02);
      mode <= FPA_MODE_ICP;
      do_call(`FPA_FN_MISC_WRITE, `FPA_SEL_CFG, 8'h55, `FPA_KEY_VALUE, -1);
      check({got, carry}, 2'b10);
      mode <= FPA_MODE_PAR;
      do_call(`FPA_FN_MISC_WRITE, `FPA_SEL_CLR_PROT, 8'h00, `FPA_KEY_VALUE, -1);
      check({carry, config_write_protect_bit, disable_clear_protect_bit}, 3'b000);
   endtask : t_protect

   task automatic t_clear;
      mode <= FPA_MODE_IAP;
      do_call(`FPA_FN_MISC_WRITE, `FPA_SEL_BOOT_STATUS_BYTE, 8'h40, `FPA_KEY_VALUE, -1);
      check({carry, config_write_protect_bit, disable_clear_protect_bit}, 3'b010);
      do_call(`FPA_FN_MISC_WRITE, `FPA_SEL_CLR_PROT, 8'h00, `FPA_KEY_VALUE, -1);
      check({got, carry, config_write_protect_bit}, 3'b100);
      do_call(`FPA_FN_MISC_WRITE, `FPA_SEL_CFG, 8'h55, `FPA_KEY_VALUE, -1);
      check({got, carry}, 2'b10);
      do_call(`FPA_FN_MISC_WRITE, `FPA_SEL_SEC_LO, 8'hAA, `FPA_KEY_VALUE, -1);
      check({got, start_seen, carry}, 3'b110);
      do_call(`FPA_FN_MISC_WRITE, 8'h04, 8'hAA, `FPA_KEY_VALUE, -1);
      check({got, start_seen, carry}, 3'b101);
      check(ret, 8'h02);
   endtask : t_clear

   task automatic t_badkey;
      do_call(`FPA_FN_PROG_PAGE, 8'h40, 8'h00, 8'h69, -1);
      check({got, rst_seen}, 2'b01);
   endtask : t_badkey

   initial begin
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      check({carry, config_write_protect_bit, disable_clear_protect_bit}, 3'b000);
      check(bsb, `FPA_BOOT_STATUS_BYTE_RST);
      t_version();
      t_program();
      t_irq();
      t_faults();
      t_protect();
      t_clear();
      t_badkey();
      end_of_test();
   end
endmodule : flash_config_protect_and_iap_calls_tb

`default_nettype wire
